// ---- rtl/nsrb_pkg.sv ----
// Package of offsets, field positions, reset values and types for the system register bank
package nsrb_pkg;
   // ----------------------------------------
   // Register offsets in the nibble space
   // ----------------------------------------
   localparam logic [4:0] OFS_IRQ_ENABLE = 5'h00;
   localparam logic [4:0] OFS_IRQ_REQUEST = 5'h01;
   localparam logic [4:0] OFS_PRESCALE = 5'h02;
   localparam logic [4:0] OFS_TIMER_LOW = 5'h04;
   localparam logic [4:0] OFS_TIMER_HIGH = 5'h05;
   localparam logic [4:0] OFS_PORT_ONE = 5'h08;
   localparam logic [4:0] OFS_PORT_TWO = 5'h09;
   localparam logic [4:0] OFS_PORT_THREE = 5'h0A;
   localparam logic [4:0] OFS_PORT_FOUR = 5'h0B;
   localparam logic [4:0] OFS_PORT_FIVE = 5'h0C;
   localparam logic [4:0] OFS_REMOTE = 5'h0D;
   localparam logic [4:0] OFS_TABLE_BRANCH = 5'h0E;
   localparam logic [4:0] OFS_INDIRECT = 5'h0F;
   localparam logic [4:0] OFS_POINTER_LOW = 5'h10;
   localparam logic [4:0] OFS_POINTER_MID = 5'h11;
   localparam logic [4:0] OFS_POINTER_HIGH = 5'h12;
   localparam logic [4:0] OFS_PULL_CARRIER = 5'h13;
   localparam logic [4:0] OFS_WATCHDOG = 5'h14;
   localparam logic [4:0] OFS_BROWNOUT = 5'h15;
   localparam logic [4:0] OFS_DIR_ONE = 5'h16;
   localparam logic [4:0] OFS_DIR_TWO = 5'h17;
   localparam logic [4:0] OFS_DIR_THREE = 5'h18;
   localparam logic [4:0] OFS_DIR_FOUR = 5'h19;
   localparam logic [4:0] OFS_DIR_FIVE = 5'h1A;
   localparam logic [4:0] OFS_CARR_LOW_LO = 5'h1B;
   localparam logic [4:0] OFS_CARR_LOW_HI = 5'h1C;
   localparam logic [4:0] OFS_CARR_HIGH_LO = 5'h1D;
   localparam logic [4:0] OFS_CARR_HIGH_HI = 5'h1E;
   // ----------------------------------------
   // Field positions and masks
   // ----------------------------------------
   localparam int BIT_TIMER_IRQ = 2;
   localparam int BIT_PORT_IRQ = 0;
   localparam int BIT_PULL_GLOBAL = 3;
   localparam int BIT_WATCHDOG = 3;
   localparam int BIT_REMOTE = 0;
   localparam logic [3:0] MASK_IRQ = 4'h5;
   localparam logic [3:0] MASK_THREE_BIT = 4'h7;
   localparam logic [3:0] MASK_PORT_FULL = 4'hF;
   localparam logic [3:0] MASK_PORT_FOUR = 4'h7;
   localparam logic [3:0] MASK_PORT_FIVE = 4'h3;
   localparam logic [3:0] MASK_DIR_FOUR = 4'h6;
   // ----------------------------------------
   // Reset values and codes
   // ----------------------------------------
   localparam logic [3:0] RST_NIBBLE = 4'h0;
   localparam logic [3:0] RST_BROWNOUT = 4'h0;
   localparam logic [3:0] CODE_BROWNOUT_OFF = 4'hA;
   // ----------------------------------------
   // Timing: one instruction cycle is four clocks
   // ----------------------------------------
   localparam int CLOCKS_PER_INSTR = 4;
   localparam logic [1:0] PHASE_LAST = 2'(CLOCKS_PER_INSTR - 1);
   // Five nibble-wide ports travel together
   typedef struct packed {
      logic [3:0] p5;
      logic [3:0] p4;
      logic [3:0] p3;
      logic [3:0] p2;
      logic [3:0] p1;
   } nsrb_ports_t;
endpackage : nsrb_pkg

// ---- rtl/nsrb_bank.sv ----
// System register bank of a nibble-wide remote-control microcontroller
module nsrb_bank
   import nsrb_pkg::*;
(
   input wire logic mclk_i,               // System clock
   input wire logic rst_n_i,              // Asynchronous reset, active low
   input wire logic [4:0] addr_i,         // Register address
   input wire logic wr_en_i,              // Write strobe
   input wire logic rd_en_i,              // Read strobe
   input wire logic [3:0] wdata_i,        // Write nibble
   output logic [3:0] rdata_o,            // Read nibble
   output logic rd_valid_o,               // Read answer strobe
   output logic [9:0] mem_addr_o,         // Data memory address
   output logic mem_we_o,                 // Data memory write
   output logic mem_re_o,                 // Data memory read
   output logic [3:0] mem_wdata_o,        // Data memory write nibble
   input wire logic [3:0] mem_rdata_i,    // Data memory read nibble
   input wire logic timer_irq_set_i,      // Timer overflow event
   input wire logic port_irq_set_i,       // Port edge event
   output logic timer_irq_enable_o,       // Timer interrupt enable
   output logic port_irq_enable_o,        // Port interrupt enable
   output logic timer_irq_request_o,      // Timer request flag
   output logic port_irq_request_o,       // Port request flag
   output logic [2:0] timer_prescale_select_o,
   output logic timer_load_o,             // Counter reload pulse
   output logic [7:0] timer_load_value_o, // Reload value
   input wire logic [7:0] timer_count_i,  // Live counter
   output logic remote_output_value_o,    // Remote data bit
   input wire logic carrier_output_pin_i, // Present carrier pin level
   output logic [3:0] table_branch_high_o,
   output logic [2:0] carrier_divider_select_o,
   output logic [7:0] carrier_low_reload_o,
   output logic [7:0] carrier_high_reload_o,
   output logic watchdog_clear_o,         // Watchdog restart pulse
   input wire logic watchdog_flag_i,      // Watchdog status
   output logic brownout_disable_o,       // Brownout reset disabled
   input wire logic osc_internal_i,       // Internal oscillator option
   input wire nsrb_ports_t pin_in_i,      // Pin levels
   output nsrb_ports_t pin_out_o,         // Pin output values
   output nsrb_ports_t pin_oe_o,          // Pin output enables
   output nsrb_ports_t pulldown_en_o,     // Pull-low switch per pin
   output logic instr_cycle_o             // One pulse per instruction cycle
);
   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta; // First stage, read only by second
   logic rst_sync_n; // Released copy used everywhere
   // Two stages so release is clean against the clock
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [3:0] irq_enable, irq_request; // Enable and request nibbles
   logic [3:0] prescale; // Timer prescale
   logic [3:0] timer_low_buf, timer_low_hold; // Low write buffer, low read hold
   logic [3:0] table_branch, ptr_low, ptr_mid, ptr_high; // Branch and pointer nibbles
   logic [3:0] pull_carrier, brownout_code; // Pull bit with divider; brownout code
   logic remote_value;
   logic [7:0] carr_low, carr_high; // Carrier reload bytes
   nsrb_ports_t port_latch; // Port data latches
   nsrb_ports_t port_dir; // Port direction bits
   logic [1:0] phase; // Instruction phase counter

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   // Write or read strobe for one location
   function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs, input logic en);
      hit = en && (a == ofs);
   endfunction

   // Inputs read the pin, outputs read the latch
   function automatic logic [3:0] port_read(input logic [3:0] latch, input logic [3:0] dir,
                                            input logic [3:0] pin, input logic [3:0] mask);
      port_read = ((dir & latch) | (~dir & pin)) & mask;
   endfunction

   wire we_irq_en = hit(addr_i, OFS_IRQ_ENABLE, wr_en_i);
   wire we_irq_req = hit(addr_i, OFS_IRQ_REQUEST, wr_en_i);
   wire we_timer_low = hit(addr_i, OFS_TIMER_LOW, wr_en_i);
   wire we_timer_high = hit(addr_i, OFS_TIMER_HIGH, wr_en_i);
   wire re_timer_high = hit(addr_i, OFS_TIMER_HIGH, rd_en_i);
   wire we_watchdog = hit(addr_i, OFS_WATCHDOG, wr_en_i);
   wire we_indirect = hit(addr_i, OFS_INDIRECT, wr_en_i);
   wire re_indirect = hit(addr_i, OFS_INDIRECT, rd_en_i);
   // External resonator owns the fifth port pins
   wire [3:0] p5_mask = osc_internal_i ? MASK_PORT_FIVE : 4'h0;

   // Next request flags: event set wins over software clear
   wire [3:0] req_set = {1'b0, timer_irq_set_i, 1'b0, port_irq_set_i};
   wire [3:0] req_sw = we_irq_req ? (wdata_i & MASK_IRQ) : irq_request;
   wire [3:0] next_irq_request = req_sw | req_set;

   // ----------------------------------------
   // Interrupt and timer registers
   // ----------------------------------------
   // enable and request nibbles
   always_ff @(posedge mclk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_enable <= RST_NIBBLE;
         irq_request <= RST_NIBBLE;
      end else begin
         if (we_irq_en) irq_enable <= wdata_i & MASK_IRQ;
         irq_request <= next_irq_request;
      end
   end

   // prescale, low buffered until high written
   always_ff @(posedge mclk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         prescale <= RST_NIBBLE;
         timer_low_buf <= RST_NIBBLE;
         timer_low_hold <= RST_NIBBLE;
      end else begin
         if (hit(addr_i, OFS_PRESCALE, wr_en_i)) prescale <= wdata_i & MASK_THREE_BIT;
         if (we_timer_low) timer_low_buf <= wdata_i;
         // high read freezes low half for next read
         if (re_timer_high) timer_low_hold <= timer_count_i[3:0];
      end
   end

   // high nibble write reloads the counter
   always_ff @(posedge mclk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         timer_load_o <= 1'b0;
         timer_load_value_o <= 8'h00;
      end else begin
         timer_load_o <= we_timer_high;
         if (we_timer_high) timer_load_value_o <= {wdata_i, timer_low_buf};
      end
   end

   // ----------------------------------------
   // Pointer, branch, carrier and control
   // ----------------------------------------
   // pointers, divider and pull bit, reloads
   always_ff @(posedge mclk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         table_branch <= RST_NIBBLE;
         ptr_low <= RST_NIBBLE;
         ptr_mid <= RST_NIBBLE;
         ptr_high <= RST_NIBBLE;
         pull_carrier <= RST_NIBBLE; // pull-lows off
         remote_value <= 1'b0;
         carr_low <= 8'h00;
         carr_high <= 8'h00;
      end else begin
         if (hit(addr_i, OFS_TABLE_BRANCH, wr_en_i)) table_branch <= wdata_i;
         if (hit(addr_i, OFS_POINTER_LOW, wr_en_i)) ptr_low <= wdata_i;
         if (hit(addr_i, OFS_POINTER_MID, wr_en_i)) ptr_mid <= wdata_i & MASK_THREE_BIT;
         if (hit(addr_i, OFS_POINTER_HIGH, wr_en_i)) ptr_high <= wdata_i & MASK_THREE_BIT;
         if (hit(addr_i, OFS_PULL_CARRIER, wr_en_i)) pull_carrier <= wdata_i;
         // write side stores the remote data bit
         if (hit(addr_i, OFS_REMOTE, wr_en_i)) remote_value <= wdata_i[BIT_REMOTE];
         if (hit(addr_i, OFS_CARR_LOW_LO, wr_en_i)) carr_low[3:0] <= wdata_i;
         if (hit(addr_i, OFS_CARR_LOW_HI, wr_en_i)) carr_low[7:4] <= wdata_i;
         if (hit(addr_i, OFS_CARR_HIGH_LO, wr_en_i)) carr_high[3:0] <= wdata_i;
         if (hit(addr_i, OFS_CARR_HIGH_HI, wr_en_i)) carr_high[7:4] <= wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         watchdog_clear_o <= 1'b0;
         brownout_code <= RST_BROWNOUT;
      end else begin
         watchdog_clear_o <= we_watchdog && wdata_i[BIT_WATCHDOG];
         if (hit(addr_i, OFS_BROWNOUT, wr_en_i)) brownout_code <= wdata_i;
      end
   end

   // ----------------------------------------
   // Ports
   // ----------------------------------------
   // data latches, directions reset to input
   always_ff @(posedge mclk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         port_latch <= '0;
         port_dir <= '0;
      end else begin
         if (hit(addr_i, OFS_PORT_ONE, wr_en_i)) port_latch.p1 <= wdata_i;
         if (hit(addr_i, OFS_PORT_TWO, wr_en_i)) port_latch.p2 <= wdata_i;
         if (hit(addr_i, OFS_PORT_THREE, wr_en_i)) port_latch.p3 <= wdata_i;
         if (hit(addr_i, OFS_PORT_FOUR, wr_en_i)) port_latch.p4 <= wdata_i & MASK_PORT_FOUR;
         if (hit(addr_i, OFS_PORT_FIVE, wr_en_i)) port_latch.p5 <= wdata_i & MASK_PORT_FIVE;
         if (hit(addr_i, OFS_DIR_ONE, wr_en_i)) port_dir.p1 <= wdata_i;
         if (hit(addr_i, OFS_DIR_TWO, wr_en_i)) port_dir.p2 <= wdata_i;
         if (hit(addr_i, OFS_DIR_THREE, wr_en_i)) port_dir.p3 <= wdata_i;
         if (hit(addr_i, OFS_DIR_FOUR, wr_en_i)) port_dir.p4 <= wdata_i & MASK_DIR_FOUR;
         if (hit(addr_i, OFS_DIR_FIVE, wr_en_i)) port_dir.p5 <= wdata_i & MASK_PORT_FIVE;
      end
   end

   // fifth port only usable on internal oscillator
   wire [3:0] p5_oe = port_dir.p5 & p5_mask;
   assign pin_out_o = port_latch;
   assign pin_oe_o = '{p5: p5_oe, p4: port_dir.p4, p3: port_dir.p3,
                       p2: port_dir.p2, p1: port_dir.p1};
   // one global bit gates every pull-low, latch selects per input pin
   wire pull_on = pull_carrier[BIT_PULL_GLOBAL];
   wire [19:0] pull_bits = {20{pull_on}} & port_latch & ~pin_oe_o;
   assign pulldown_en_o = {pull_bits[19:16] & p5_mask, pull_bits[15:0]};

   // ----------------------------------------
   // Instruction cycle phase
   // ----------------------------------------
   // four clocks per instruction cycle
   always_ff @(posedge mclk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         phase <= 2'h0;
      end else begin
         phase <= (phase == PHASE_LAST) ? 2'h0 : phase + 2'h1;
      end
   end
   assign instr_cycle_o = rst_sync_n && (phase == PHASE_LAST);

   // ----------------------------------------
   // Indirect memory window and read path
   // ----------------------------------------
   // pointer forms ten-bit memory address
   assign mem_addr_o = {ptr_high[2:0], ptr_mid[2:0], ptr_low};
   assign mem_we_o = we_indirect;
   assign mem_re_o = re_indirect;
   assign mem_wdata_o = wdata_i;

   // Read mux; unlisted locations answer zero
   function automatic logic [3:0] read_mux(input logic [4:0] a);
      unique case (a)
         OFS_IRQ_ENABLE: read_mux = irq_enable;
         OFS_IRQ_REQUEST: read_mux = irq_request;
         OFS_PRESCALE: read_mux = prescale;
         OFS_TIMER_LOW: read_mux = timer_low_hold;
         OFS_TIMER_HIGH: read_mux = timer_count_i[7:4];
         OFS_PORT_ONE: read_mux = port_read(port_latch.p1, port_dir.p1, pin_in_i.p1,
                                           MASK_PORT_FULL);
         OFS_PORT_TWO: read_mux = port_read(port_latch.p2, port_dir.p2, pin_in_i.p2,
                                           MASK_PORT_FULL);
         OFS_PORT_THREE: read_mux = port_read(port_latch.p3, port_dir.p3, pin_in_i.p3,
                                             MASK_PORT_FULL);
         OFS_PORT_FOUR: read_mux = port_read(port_latch.p4, port_dir.p4, pin_in_i.p4,
                                            MASK_PORT_FOUR);
         OFS_PORT_FIVE: read_mux = port_read(port_latch.p5, port_dir.p5, pin_in_i.p5, p5_mask);
         // read side shows the live carrier pin
         OFS_REMOTE: read_mux = {3'h0, carrier_output_pin_i};
         OFS_TABLE_BRANCH: read_mux = table_branch;
         OFS_INDIRECT: read_mux = mem_rdata_i;
         OFS_POINTER_LOW: read_mux = ptr_low;
         OFS_POINTER_MID: read_mux = ptr_mid;
         OFS_POINTER_HIGH: read_mux = ptr_high;
         OFS_PULL_CARRIER: read_mux = pull_carrier;
         OFS_WATCHDOG: read_mux = {watchdog_flag_i, 3'h0};
         OFS_BROWNOUT: read_mux = brownout_code;
         OFS_DIR_ONE: read_mux = port_dir.p1;
         OFS_DIR_TWO: read_mux = port_dir.p2;
         OFS_DIR_THREE: read_mux = port_dir.p3;
         OFS_DIR_FOUR: read_mux = port_dir.p4;
         OFS_DIR_FIVE: read_mux = port_dir.p5;
         OFS_CARR_LOW_LO: read_mux = carr_low[3:0];
         OFS_CARR_LOW_HI: read_mux = carr_low[7:4];
         OFS_CARR_HIGH_LO: read_mux = carr_high[3:0];
         OFS_CARR_HIGH_HI: read_mux = carr_high[7:4];
         default: read_mux = 4'h0;
      endcase
   endfunction

   // Process form: a net would miss reads made inside the function
   logic [3:0] next_rdata;
   always_comb next_rdata = read_mux(addr_i);

   // Answer registered one clock after the strobe
   always_ff @(posedge mclk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rdata_o <= 4'h0;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= rd_en_i;
         if (rd_en_i) rdata_o <= next_rdata;
      end
   end

   // ----------------------------------------
   // Outputs to the peripherals
   // ----------------------------------------
   assign timer_irq_enable_o = irq_enable[BIT_TIMER_IRQ];
   assign port_irq_enable_o = irq_enable[BIT_PORT_IRQ];
   assign timer_irq_request_o = irq_request[BIT_TIMER_IRQ];
   assign port_irq_request_o = irq_request[BIT_PORT_IRQ];
   assign timer_prescale_select_o = prescale[2:0];
   assign remote_output_value_o = remote_value;
   assign table_branch_high_o = table_branch;
   assign carrier_divider_select_o = pull_carrier[2:0];
   assign carrier_low_reload_o = carr_low;
   assign carrier_high_reload_o = carr_high;
   // only the one code disables brownout reset
   assign brownout_disable_o = (brownout_code == CODE_BROWNOUT_OFF);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_sync_n);

   sequence s_quiet3;
      !instr_cycle_o [*3];
   endsequence
   property p_timer_irq_set_wins;
      timer_irq_set_i |=> timer_irq_request_o;
   endproperty
   a_timer_irq_set_wins: assert property (p_timer_irq_set_wins)
      else $error("timer request lost");
   property p_timer_reload;
      we_timer_high |=> timer_load_o && timer_load_value_o == {$past(wdata_i), $past(timer_low_buf)};
   endproperty
   a_timer_reload: assert property (p_timer_reload)
      else $error("timer reload wrong");
   property p_low_no_reload;
      (we_timer_low && !we_timer_high) |=> !timer_load_o;
   endproperty
   a_low_no_reload: assert property (p_low_no_reload)
      else $error("low write reloaded counter");
   property p_remote_read;
      hit(addr_i, OFS_REMOTE, rd_en_i) |=> rdata_o == {3'h0, $past(carrier_output_pin_i)};
   endproperty
   a_remote_read: assert property (p_remote_read)
      else $error("remote read not pin state");
   property p_indirect;
      hit(addr_i, OFS_POINTER_LOW, wr_en_i) |=> mem_addr_o[3:0] == $past(wdata_i);
   endproperty
   a_indirect: assert property (p_indirect)
      else $error("indirect address wrong");
   property p_watchdog;
      (we_watchdog && wdata_i[BIT_WATCHDOG])
         |=> watchdog_clear_o ##1 (watchdog_clear_o == $past(we_watchdog && wdata_i[BIT_WATCHDOG]));
   endproperty
   a_watchdog: assert property (p_watchdog)
      else $error("watchdog restart missing");
   property p_brownout;
      hit(addr_i, OFS_BROWNOUT, wr_en_i) |=> brownout_disable_o == ($past(wdata_i) == CODE_BROWNOUT_OFF);
   endproperty
   a_brownout: assert property (p_brownout)
      else $error("brownout code misread");
   property p_dir_four_bit0;
      hit(addr_i, OFS_DIR_FOUR, rd_en_i) |=> rd_valid_o && !rdata_o[0];
   endproperty
   a_dir_four_bit0: assert property (p_dir_four_bit0)
      else $error("input-only direction bit set");
   property p_reserved;
      (rd_en_i && (addr_i == 5'h03 || addr_i == 5'h06 || addr_i == 5'h07 || addr_i == 5'h1F))
         |=> rdata_o == 4'h0;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved read not zero");
   property p_instr_cycle;
      instr_cycle_o |=> s_quiet3 ##1 instr_cycle_o;
   endproperty
   a_instr_cycle: assert property (p_instr_cycle)
      else $error("instruction cycle not four clocks");
   property p_pull_off;
      !pull_on |-> pulldown_en_o == '0;
   endproperty
   a_pull_off: assert property (p_pull_off)
      else $error("pull-low on while disabled");
endmodule // nsrb_bank

// ---- testbench/nsrb_bank_tb.sv ----
// Self-checking bench for the system register bank
module nsrb_bank_tb
   import nsrb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, wr_en_i = 1'b0, rd_en_i = 1'b0, osc_internal_i = 1'b1;
   logic carrier_output_pin_i = 1'b0, watchdog_flag_i = 1'b1, tset = 1'b0;
   logic [4:0] addr_i = 5'h00;
   logic [3:0] wdata_i = 4'h0, mem_rdata_i = 4'h0, rdata_o, mem_wdata_o, table_branch_high;
   logic [7:0] timer_count_i = 8'h00, tval, clow, chigh;
   logic rd_valid_o, mem_we_o, mem_re_o, tload, wclr, bdis, rov, ic, ten, pen, treq, preq;
   logic [9:0] mem_addr_o;
   logic [2:0] psel, cdiv;
   logic [4:0] m;
   logic [5:0] cap;
   nsrb_ports_t pin_in_i = '0, pin_oe_o, pulldown_en_o, pout;
   int err_count = 0, num_checks = 0, ic_n = 0;
   logic [3:0] exp_q[$];
   logic [3:0] sh [32];
   logic [31:0] rnd = 32'h3866;
   // One event strobe feeds both request flags, to race it against a clear
   nsrb_bank nsrb_bank_inst (.mclk_i, .rst_n_i, .addr_i, .wr_en_i, .rd_en_i, .wdata_i, .rdata_o,
      .rd_valid_o, .mem_addr_o, .mem_we_o, .mem_re_o, .mem_wdata_o, .mem_rdata_i,
      .timer_irq_set_i(tset), .port_irq_set_i(tset), .timer_irq_enable_o(ten),
      .port_irq_enable_o(pen), .timer_irq_request_o(treq), .port_irq_request_o(preq),
      .timer_prescale_select_o(psel), .timer_load_o(tload), .timer_load_value_o(tval),
      .timer_count_i, .remote_output_value_o(rov), .carrier_output_pin_i,
      .table_branch_high_o(table_branch_high), .carrier_divider_select_o(cdiv), .carrier_low_reload_o(clow),
      .carrier_high_reload_o(chigh), .watchdog_clear_o(wclr), .watchdog_flag_i,
      .brownout_disable_o(bdis), .osc_internal_i, .pin_in_i, .pin_out_o(pout), .pin_oe_o,
      .pulldown_en_o, .instr_cycle_o(ic));
   initial forever #5 mclk_i = ~mclk_i;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Bit4 marks a plain read-back place, low bits are the writable mask
   function automatic logic [4:0] msk(input int a);
      case (a)
         0, 1: return 5'h15;
         2, 17, 18: return 5'h17;
         25: return 5'h16;
         26: return 5'h13;
         3, 6, 7, 31: return 5'h10;
         8, 9, 10: return 5'h0F;
         11: return 5'h07;
         12: return 5'h03;
         4, 5, 13, 15, 20: return 5'h00;
         default: return 5'h1F;
      endcase
   endfunction
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One cycle of the register bus, driven off the sampling edge
   task automatic bus(input logic we, input logic re, input logic [4:0] a, input logic [3:0] d);
      wr_en_i = we;
      rd_en_i = re;
      addr_i = a;
      wdata_i = d;
      #1 cap = {mem_wdata_o, mem_we_o, mem_re_o};
      @(negedge mclk_i);
   endtask
   task automatic rd(input logic [4:0] a, input logic [3:0] e);
      exp_q.push_back(e);
      bus(1'b0, 1'b1, a, 4'h0);
   endtask
   task automatic print_verdict;
      if (err_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Read answers are compared in order of issue
   always @(negedge mclk_i) begin
      if (rd_valid_o === 1'b1) begin
         chk({6'h00, rdata_o}, {6'h00, exp_q.pop_front()});
      end
   end
   initial begin
      repeat (5000) @(posedge mclk_i);
      err_count++;
      print_verdict();
   end
   initial begin
      repeat (3) @(negedge mclk_i);
      rst_n_i = 1'b1;
      repeat (3) @(negedge mclk_i);
      rd(OFS_BROWNOUT, RST_BROWNOUT);
      rd(OFS_PULL_CARRIER, RST_NIBBLE);
      rd(OFS_DIR_ONE, RST_NIBBLE);
      for (int i = 0; i < 32; i++) begin
         rnd = lfsr(rnd);
         m = msk(i);
         sh[i] = rnd[3:0] & m[3:0];
         bus(1'b1, 1'b0, 5'(i), rnd[3:0]);
         if (m[4]) rd(5'(i), sh[i]);
      end
      chk({2'b00, clow}, {2'b00, sh[28], sh[27]});
      chk({2'b00, chigh}, {2'b00, sh[30], sh[29]});
      chk({6'h00, ten, pen, treq, preq}, {6'h00, sh[0][2], sh[0][0], sh[1][2], sh[1][0]});
      chk({3'h0, psel, table_branch_high}, {3'h0, sh[2][2:0], sh[14]});
      chk({7'h00, cdiv}, {7'h00, sh[19][2:0]});
      chk({2'b00, pout.p2, pout.p1}, {2'b00, sh[9], sh[8]});
      chk({2'b00, pout.p4, pout.p3}, {2'b00, sh[11], sh[10]});
      chk({6'h00, pout.p5}, {6'h00, sh[12]});
      tset = 1'b1;
      bus(1'b1, 1'b0, OFS_IRQ_REQUEST, 4'h0);
      tset = 1'b0;
      chk({8'h00, treq, preq}, 10'h003);
      rd(OFS_IRQ_REQUEST, 4'h5);
      chk(mem_addr_o, {sh[18][2:0], sh[17][2:0], sh[16]});
      mem_rdata_i = rnd[7:4];
      rd(OFS_INDIRECT, rnd[7:4]);
      chk({4'h0, cap}, 10'h001);
      bus(1'b1, 1'b0, OFS_INDIRECT, 4'h3);
      chk({4'h0, cap}, 10'h00E);
      bus(1'b1, 1'b0, OFS_TIMER_LOW, rnd[11:8]);
      bus(1'b1, 1'b0, OFS_TIMER_HIGH, rnd[15:12]);
      chk({1'b0, tload, tval}, {2'b01, rnd[15:8]});
      timer_count_i = rnd[23:16];
      rd(OFS_TIMER_HIGH, rnd[23:20]);
      timer_count_i = ~rnd[23:16];
      rd(OFS_TIMER_LOW, rnd[19:16]);
      bus(1'b1, 1'b0, OFS_REMOTE, 4'hF);
      chk({9'h000, rov}, 10'h001);
      rd(OFS_REMOTE, 4'h0);
      bus(1'b1, 1'b0, OFS_WATCHDOG, 4'h8);
      chk({9'h000, wclr}, 10'h001);
      rd(OFS_WATCHDOG, 4'h8);
      for (int v = 0; v < 16; v++) begin
         bus(1'b1, 1'b0, OFS_BROWNOUT, 4'(v));
         chk({9'h000, bdis}, {9'h000, 4'(v) == CODE_BROWNOUT_OFF});
      end
      bus(1'b1, 1'b0, OFS_PORT_FIVE, 4'h3);
      bus(1'b1, 1'b0, OFS_DIR_FIVE, 4'h3);
      bus(1'b1, 1'b0, OFS_PULL_CARRIER, 4'h8);
      bus(1'b1, 1'b0, OFS_DIR_ONE, 4'h5);
      bus(1'b1, 1'b0, OFS_PORT_ONE, 4'hF);
      chk({6'h00, pulldown_en_o.p1}, 10'h00A);
      chk({6'h00, pulldown_en_o.p5}, 10'h000);
      chk({6'h00, pin_oe_o.p1}, 10'h005);
      pin_in_i.p1 = rnd[27:24];
      rd(OFS_PORT_ONE, 4'h5 | (4'hA & rnd[27:24]));
      bus(1'b1, 1'b0, OFS_DIR_FIVE, 4'h3);
      chk({6'h00, pin_oe_o.p5}, 10'h003);
      osc_internal_i = 1'b0;
      bus(1'b0, 1'b0, OFS_PULL_CARRIER, 4'h0);
      chk({6'h00, pin_oe_o.p5}, 10'h000);
      repeat (40) begin
         @(negedge mclk_i);
         ic_n += int'(ic);
      end
      chk(10'(ic_n), 10'd10);
      chk(10'(exp_q.size()), 10'h000);
      print_verdict();
   end
endmodule // nsrb_bank_tb
